// File: rtl/pte_regs.svh
// Register indexes, field positions and reset values of the trip and event trigger block
`ifndef PTE_REGS_SVH
`define PTE_REGS_SVH

// Register indexes; byte address is four times the index
`define PTE_IDX_TRIP_SRC 6'h12
`define PTE_IDX_TRIP_ACT 6'h14
`define PTE_IDX_TRIP_IEN 6'h15
`define PTE_IDX_TRIP_FLG 6'h16
`define PTE_IDX_TRIP_CLR 6'h17
`define PTE_IDX_TRIP_FRC 6'h18
`define PTE_IDX_EVT_SEL 6'h19
`define PTE_IDX_EVT_PS 6'h1A
`define PTE_IDX_EVT_FLG 6'h1B
`define PTE_IDX_EVT_CLR 6'h1C
`define PTE_IDX_EVT_FRC 6'h1D

// Trip source select fields
`define PTE_SRC_CBC_LSB 0
`define PTE_SRC_OST_LSB 8

// Trip action fields
`define PTE_ACT_A_LSB 0
`define PTE_ACT_B_LSB 2

// Trip flag, clear, force and enable bits
`define PTE_TRIP_INT_BIT 0
`define PTE_TRIP_CBC_BIT 1
`define PTE_TRIP_OST_BIT 2

// Event select fields
`define PTE_SEL_IRQ_LSB 0
`define PTE_SEL_IRQ_EN_BIT 3
`define PTE_SEL_CONV_START_A_LSB 8
`define PTE_SEL_CONV_START_A_EN_BIT 11
`define PTE_SEL_CONV_START_B_LSB 12
`define PTE_SEL_CONV_START_B_EN_BIT 15

// Event prescale fields
`define PTE_PS_IRQ_PRD_LSB 0
`define PTE_PS_IRQ_CNT_LSB 2
`define PTE_PS_CONV_START_A_PRD_LSB 8
`define PTE_PS_CONV_START_A_CNT_LSB 10
`define PTE_PS_CONV_START_B_PRD_LSB 12
`define PTE_PS_CONV_START_B_CNT_LSB 14

// Event flag, clear and force bits
`define PTE_EVT_IRQ_BIT 0
`define PTE_EVT_CONV_START_A_BIT 2
`define PTE_EVT_CONV_START_B_BIT 3

// Reset values
`define PTE_RST_WORD16 16'h0000
`define PTE_RST_ACT 4'hF
`define PTE_RST_CNT 2'h0

`endif

// File: rtl/pte_pkg.sv
// Types shared by the trip and event trigger block
package pte_pkg;

  // Time-base and compare events, all one-cycle pulses except the direction level
  typedef struct packed {
    logic zero;
    logic period;
    logic compare_a_value;
    logic compare_b_value;
    logic count_up;
  } pte_tb_evt_type;

  // Action applied to an output while tripped
  typedef enum logic [1:0] {
    PTE_ACT_HIZ = 2'h0,
    PTE_ACT_HIGH = 2'h1,
    PTE_ACT_LOW = 2'h2,
    PTE_ACT_NONE = 2'h3
  } pte_act_type;

  // Event source codes for the interrupt and conversion-start paths
  typedef enum logic [2:0] {
    PTE_SRC_OFF = 3'h0,
    PTE_SRC_ZERO = 3'h1,
    PTE_SRC_PERIOD = 3'h2,
    PTE_SRC_RSVD = 3'h3,
    PTE_SRC_COMPARE_A_VALUE_UP = 3'h4,
    PTE_SRC_COMPARE_A_VALUE_DN = 3'h5,
    PTE_SRC_COMPARE_B_VALUE_UP = 3'h6,
    PTE_SRC_COMPARE_B_VALUE_DN = 3'h7
  } pte_src_type;

  // One driven output pin: level and enable
  typedef struct packed {
    logic level;
    logic oe;
  } pte_pin_type;

endpackage : pte_pkg

// File: rtl/pte_top.sv
// Trip response and event trigger unit with APB register access
// Behaviour
// - One-shot trip applies action, sets flag
// - Trip interrupt only when its enable set
// - One-shot trip holds until software clears
// - Per-output action: hiz, high, low, unchanged
// - One interrupt, two conversion-start outputs
// - Interrupt period: off, every 1/2/3 events
// - Six selectable event sources
// - Readable counter stops at period
// - At period, enabled, flag clear: pulse, reset
// - Disabled or pending: counter halts at period
// - Pending output held until flag cleared
// - Period write zeroes counter, no interrupt
// - Force bit counts like a real event
// - Period zero disables counting and force
// - Conversion start A pulses keep repeating
// - Disabled start suppresses pulses, still counts
// - Each start path has own source select
// - Start B mirrors start A independently
// - Clear bit per flag; force bit per flag except trip interrupt
// - Per-cycle trip releases at counter zero
`timescale 1ns/1ps
`default_nettype none
`include "pte_regs.svh"

// ----------------------------------------------------------------------
// Event prescaler shared by the interrupt and both start paths
// ----------------------------------------------------------------------
module pte_prescaler #(
  parameter bit BLOCKING = 1'b1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Events and control
  input wire logic event_in,
  input wire logic force_in,
  input wire logic period_wr,
  input wire logic [1:0] period,
  input wire logic enable,
  input wire logic flag,
  // Count and fire request
  output logic [1:0] count_q,
  output logic fire
);
  logic [1:0] count_d; // Next count
  wire active = period != 2'h0; // Zero period switches the counter off
  wire at_period = active && (count_q == period); // Counter has reached the period
  wire tick = active && (event_in || force_in); // Force counts as an event
  // Blocking paths wait for the flag; start paths fire regardless
  assign fire = at_period && enable && !(BLOCKING && flag) && !period_wr;

  // Next count: period write wins, then fire, then a counted event
  always_comb begin
    count_d = count_q;
    if (period_wr) begin
      count_d = `PTE_RST_CNT;
    end else if (fire) begin
      count_d = `PTE_RST_CNT;
    end else if (tick && !at_period) begin
      count_d = count_q + 2'h1; // Halts at period otherwise
    end
  end

  // Counter register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= `PTE_RST_CNT;
    end else if (clk_en) begin
      count_q <= count_d;
    end
  end
endmodule : pte_prescaler

// ----------------------------------------------------------------------
// Top level
// ----------------------------------------------------------------------
module pte_top
  import pte_pkg::*;
#(
  parameter int FAULT_INPUTS = 6
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Time-base and compare events
  input wire pte_tb_evt_type tb_evt,
  // Fault pins, active low
  input wire logic [FAULT_INPUTS-1:0] fault_input_n,
  // Waveforms from the action stage and driven pins
  input wire logic pwm_in_a,
  input wire logic pwm_in_b,
  output pte_pin_type pwm_output_a,
  output pte_pin_type pwm_output_b,
  // Requests toward interrupt hub and converters
  output logic trip_irq_request,
  output logic irq_pulse,
  output logic conv_start_a,
  output logic conv_start_b
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [FAULT_INPUTS-1:0] fault_meta_q; // First synchroniser stage
  logic [FAULT_INPUTS-1:0] fault_sync_q; // Second stage, active high
  logic [15:0] trip_src_q; // trip_source_select
  logic [3:0] trip_act_q; // trip_action_control
  logic [2:0] trip_ien_q; // trip_irq_enable
  logic [2:0] trip_flg_q; // trip_flags
  logic ost_q; // One-shot trip active
  logic cbc_q; // Per-cycle trip active
  logic [15:0] evt_sel_q; // event_trigger_select
  logic [1:0] irq_prd_q; // irq_event_period
  logic [1:0] conv_start_a_prd_q; // conv_start_a_period
  logic [1:0] conv_start_b_prd_q; // conversion start B period
  logic [3:0] evt_flg_q; // event_trigger_flags
  logic [1:0] irq_cnt; // irq_event_count
  logic [1:0] conv_start_a_cnt; // conv_start_a_count
  logic [1:0] conv_start_b_cnt; // conversion start B count
  logic irq_fire; // Interrupt path request
  logic conv_start_a_fire; // Start A request
  logic conv_start_b_fire; // Start B request

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  wire [5:0] idx = paddr[7:2]; // Word index
  wire wr = psel && penable && pwrite && pready; // Write takes effect here
  wire setup = psel && !penable; // Read data prepared in setup
  wire hit_src = idx == `PTE_IDX_TRIP_SRC;
  wire hit_act = idx == `PTE_IDX_TRIP_ACT;
  wire hit_ien = idx == `PTE_IDX_TRIP_IEN;
  wire hit_tflg = idx == `PTE_IDX_TRIP_FLG;
  wire hit_tclr = idx == `PTE_IDX_TRIP_CLR;
  wire hit_tfrc = idx == `PTE_IDX_TRIP_FRC;
  wire hit_sel = idx == `PTE_IDX_EVT_SEL;
  wire hit_ps = idx == `PTE_IDX_EVT_PS;
  wire hit_eflg = idx == `PTE_IDX_EVT_FLG;
  wire hit_eclr = idx == `PTE_IDX_EVT_CLR;
  wire hit_efrc = idx == `PTE_IDX_EVT_FRC;
  wire mapped = hit_src || hit_act || hit_ien || hit_tflg || hit_tclr || hit_tfrc ||
    hit_sel || hit_ps || hit_eflg || hit_eclr || hit_efrc;
  wire wr_ps = wr && hit_ps; // Any prescale write rewrites the periods
  // Write-one clear and force strobes; zeros do nothing
  wire [2:0] tclr = (wr && hit_tclr) ? pwdata[2:0] : 3'h0;
  wire [2:0] tfrc = (wr && hit_tfrc) ? pwdata[2:0] : 3'h0;
  wire [3:0] eclr = (wr && hit_eclr) ? pwdata[3:0] : 4'h0;
  wire [3:0] efrc = (wr && hit_efrc) ? pwdata[3:0] : 4'h0;

  // Read multiplexer; clear and force read as zero
  wire [15:0] ps_rd = {conv_start_b_cnt, conv_start_b_prd_q, conv_start_a_cnt, conv_start_a_prd_q, 4'h0, irq_cnt, irq_prd_q};
  wire [15:0] rd_mux = hit_src ? trip_src_q :
    hit_act ? {12'h000, trip_act_q} :
    hit_ien ? {13'h0000, trip_ien_q} :
    hit_tflg ? {13'h0000, trip_flg_q} :
    hit_sel ? evt_sel_q :
    hit_ps ? ps_rd :
    hit_eflg ? {12'h000, evt_flg_q} : 16'h0000;

  // ----------------------------------------------------------------------
  // Trip logic
  // ----------------------------------------------------------------------
  // Fault pins are active low and only a synchronised level is read
  wire cbc_evt = |(fault_sync_q & trip_src_q[`PTE_SRC_CBC_LSB +: FAULT_INPUTS]) ||
    tfrc[`PTE_TRIP_CBC_BIT];
  wire ost_evt = |(fault_sync_q & trip_src_q[`PTE_SRC_OST_LSB +: FAULT_INPUTS]) ||
    tfrc[`PTE_TRIP_OST_BIT];
  // Interrupt only for enabled causes
  wire trip_int_set = (cbc_evt && trip_ien_q[`PTE_TRIP_CBC_BIT]) ||
    (ost_evt && trip_ien_q[`PTE_TRIP_OST_BIT]);
  wire tripped = ost_q || cbc_q || ost_evt || cbc_evt; // Event acts at once
  wire [2:0] trip_set = {ost_evt, cbc_evt, trip_int_set};
  wire [2:0] trip_flg_d = trip_set | (trip_flg_q & ~tclr); // Set beats clear
  // One-shot stays until cleared by software, never by hardware
  wire ost_d = ost_evt || (ost_q && !tclr[`PTE_TRIP_OST_BIT]);
  // Per-cycle trip releases at counter zero once the cause is gone
  wire cbc_d = cbc_evt || (cbc_q && !tb_evt.zero);

  // Output action selection per pin
  function automatic pte_pin_type act_pin(input logic trip, input logic [1:0] code,
                                          input logic wave);
    pte_pin_type p;
    p.level = wave;
    p.oe = 1'b1;
    if (trip) begin
      case (pte_act_type'(code))
        PTE_ACT_HIZ: begin
          p.oe = 1'b0;
        end
        PTE_ACT_HIGH: begin
          p.level = 1'b1;
        end
        PTE_ACT_LOW: begin
          p.level = 1'b0;
        end
        default: begin
          p.level = wave; // No change
        end
      endcase
    end
    return p;
  endfunction : act_pin

  wire pte_pin_type pin_a_d = act_pin(tripped, trip_act_q[`PTE_ACT_A_LSB +: 2], pwm_in_a);
  wire pte_pin_type pin_b_d = act_pin(tripped, trip_act_q[`PTE_ACT_B_LSB +: 2], pwm_in_b);

  // ----------------------------------------------------------------------
  // Event selection and prescalers
  // ----------------------------------------------------------------------
  // Pick one of six qualified events; direction qualifies compare matches
  function automatic logic pick(input logic [2:0] code, input pte_tb_evt_type e);
    logic r;
    r = 1'b0;
    case (pte_src_type'(code))
      PTE_SRC_ZERO: r = e.zero;
      PTE_SRC_PERIOD: r = e.period;
      PTE_SRC_COMPARE_A_VALUE_UP: r = e.compare_a_value && e.count_up;
      PTE_SRC_COMPARE_A_VALUE_DN: r = e.compare_a_value && !e.count_up;
      PTE_SRC_COMPARE_B_VALUE_UP: r = e.compare_b_value && e.count_up;
      PTE_SRC_COMPARE_B_VALUE_DN: r = e.compare_b_value && !e.count_up;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : pick

  // Interrupt path blocks on its pending flag
  pte_prescaler #(.BLOCKING(1'b1)) u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .event_in(pick(evt_sel_q[`PTE_SEL_IRQ_LSB +: 3], tb_evt)),
    .force_in(efrc[`PTE_EVT_IRQ_BIT]),
    .period_wr(wr_ps),
    .period(irq_prd_q),
    .enable(evt_sel_q[`PTE_SEL_IRQ_EN_BIT]),
    .flag(evt_flg_q[`PTE_EVT_IRQ_BIT]),
    .count_q(irq_cnt),
    .fire(irq_fire)
  );

  // Start A path keeps pulsing whatever its flag
  pte_prescaler #(.BLOCKING(1'b0)) u_conv_start_a (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .event_in(pick(evt_sel_q[`PTE_SEL_CONV_START_A_LSB +: 3], tb_evt)),
    .force_in(efrc[`PTE_EVT_CONV_START_A_BIT]),
    .period_wr(wr_ps),
    .period(conv_start_a_prd_q),
    .enable(evt_sel_q[`PTE_SEL_CONV_START_A_EN_BIT]),
    .flag(evt_flg_q[`PTE_EVT_CONV_START_A_BIT]),
    .count_q(conv_start_a_cnt),
    .fire(conv_start_a_fire)
  );

  // Start B path is an independent copy of A
  pte_prescaler #(.BLOCKING(1'b0)) u_conv_start_b (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .event_in(pick(evt_sel_q[`PTE_SEL_CONV_START_B_LSB +: 3], tb_evt)),
    .force_in(efrc[`PTE_EVT_CONV_START_B_BIT]),
    .period_wr(wr_ps),
    .period(conv_start_b_prd_q),
    .enable(evt_sel_q[`PTE_SEL_CONV_START_B_EN_BIT]),
    .flag(evt_flg_q[`PTE_EVT_CONV_START_B_BIT]),
    .count_q(conv_start_b_cnt),
    .fire(conv_start_b_fire)
  );

  // Flags latch on each pulse; a set in the clear cycle survives
  wire [3:0] evt_set = {conv_start_b_fire, conv_start_a_fire, 1'b0, irq_fire};
  wire [3:0] evt_flg_d = evt_set | (evt_flg_q & ~eclr);

  // ----------------------------------------------------------------------
  // Fault synchroniser
  // ----------------------------------------------------------------------
  // Pins are asynchronous; the first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_meta_q <= '0;
      fault_sync_q <= '0;
    end else if (clk_en) begin
      fault_meta_q <= ~fault_input_n;
      fault_sync_q <= fault_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  // Software-written control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_src_q <= `PTE_RST_WORD16;
      trip_act_q <= `PTE_RST_ACT;
      trip_ien_q <= 3'h0;
      evt_sel_q <= `PTE_RST_WORD16;
      irq_prd_q <= `PTE_RST_CNT;
      conv_start_a_prd_q <= `PTE_RST_CNT;
      conv_start_b_prd_q <= `PTE_RST_CNT;
    end else if (clk_en && wr) begin
      if (hit_src) begin
        trip_src_q <= pwdata[15:0];
      end
      if (hit_act) begin
        trip_act_q <= pwdata[3:0];
      end
      if (hit_ien) begin
        trip_ien_q <= {pwdata[2:1], 1'b0};
      end
      if (hit_sel) begin
        evt_sel_q <= pwdata[15:0];
      end
      if (hit_ps) begin
        irq_prd_q <= pwdata[`PTE_PS_IRQ_PRD_LSB +: 2];
        conv_start_a_prd_q <= pwdata[`PTE_PS_CONV_START_A_PRD_LSB +: 2];
        conv_start_b_prd_q <= pwdata[`PTE_PS_CONV_START_B_PRD_LSB +: 2];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Trip and event state, outputs
  // ----------------------------------------------------------------------
  // All outputs are registered, so a trip shows at the pins one edge later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ost_q <= 1'b0;
      cbc_q <= 1'b0;
      trip_flg_q <= 3'h0;
      evt_flg_q <= 4'h0;
      pwm_output_a <= '0;
      pwm_output_b <= '0;
      trip_irq_request <= 1'b0;
      irq_pulse <= 1'b0;
      conv_start_a <= 1'b0;
      conv_start_b <= 1'b0;
    end else if (clk_en) begin
      ost_q <= ost_d;
      cbc_q <= cbc_d;
      trip_flg_q <= trip_flg_d;
      evt_flg_q <= evt_flg_d;
      pwm_output_a <= pin_a_d;
      pwm_output_b <= pin_b_d;
      trip_irq_request <= trip_flg_d[`PTE_TRIP_INT_BIT];
      irq_pulse <= irq_fire; // One cycle each
      conv_start_a <= conv_start_a_fire;
      conv_start_b <= conv_start_b_fire;
    end
  end

  // ----------------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------------
  // Zero-wait slave: ready and data prepared during the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite) ? {16'h0000, rd_mux} : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_ost_latch;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && ost_evt) |=> (ost_q && trip_flg_q[`PTE_TRIP_OST_BIT]);
  endproperty
  a_ost_latch: assert property (p_ost_latch) else $error("one-shot trip not latched");

  property p_ost_hold;
    @(posedge pclk) disable iff (!presetn)
      (ost_q && !(clk_en && tclr[`PTE_TRIP_OST_BIT])) |=> ost_q;
  endproperty
  a_ost_hold: assert property (p_ost_hold) else $error("one-shot trip released alone");

  property p_trip_irq_gate;
    @(posedge pclk) disable iff (!presetn)
      (!trip_irq_request && !(clk_en && trip_int_set)) |=> !trip_irq_request;
  endproperty
  a_trip_irq_gate: assert property (p_trip_irq_gate) else $error("trip irq not enabled");

  property p_hiz;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && ost_q && trip_act_q[1:0] == 2'h0) |=> !pwm_output_a.oe;
  endproperty
  a_hiz: assert property (p_hiz) else $error("tripped output A still driven");

  property p_irq_one;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && irq_pulse) |=> !irq_pulse;
  endproperty
  a_irq_one: assert property (p_irq_one) else $error("interrupt pulse too long");

  property p_irq_pending;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && evt_flg_q[`PTE_EVT_IRQ_BIT]) |=> !irq_pulse;
  endproperty
  a_irq_pending: assert property (p_irq_pending) else $error("interrupt while pending");

  property p_prd_clear;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && wr_ps) |=> (irq_cnt == 2'h0 && conv_start_a_cnt == 2'h0 && !irq_pulse);
  endproperty
  a_prd_clear: assert property (p_prd_clear) else $error("period write left count");

  property p_cnt_bound;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && !wr_ps) |=> (irq_cnt <= irq_prd_q);
  endproperty
  a_cnt_bound: assert property (p_cnt_bound) else $error("count passed period");

  property p_flag_wins;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && irq_fire) |=> evt_flg_q[`PTE_EVT_IRQ_BIT];
  endproperty
  a_flag_wins: assert property (p_flag_wins) else $error("interrupt flag lost");

  property p_conv_start_a_off;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && !evt_sel_q[`PTE_SEL_CONV_START_A_EN_BIT]) |=> !conv_start_a;
  endproperty
  a_conv_start_a_off: assert property (p_conv_start_a_off) else $error("disabled start A pulsed");

  property p_cbc_release;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && cbc_q && tb_evt.zero && !cbc_evt) |=> !cbc_q;
  endproperty
  a_cbc_release: assert property (p_cbc_release) else $error("per-cycle trip stuck");

endmodule : pte_top
`default_nettype wire

// File: bench/pte_partner.sv
// Model of the interrupt hub and the two converter sequencers
`timescale 1ns/1ps
`default_nettype none
module pte_partner (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests of this module and of a neighbour module
  input wire logic irq_pulse,
  input wire logic conv_start_a,
  input wire logic conv_start_b,
  input wire logic peer_start_a,
  input wire logic peer_start_b,
  // Accepted request counts
  output var int irq_seen,
  output var int conv_a_seen,
  output var int conv_b_seen
);
  // ----------------------------------------
  // Request lines
  // ----------------------------------------
  // Start lines of all modules merge before the converter
  wire logic line_a = conv_start_a | peer_start_a;
  wire logic line_b = conv_start_b | peer_start_b;
  // One request per high cycle, so coincident requests count once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_seen <= 0;
      conv_a_seen <= 0;
      conv_b_seen <= 0;
    end else begin
      irq_seen <= irq_seen + int'(irq_pulse);
      conv_a_seen <= conv_a_seen + int'(line_a);
      conv_b_seen <= conv_b_seen + int'(line_b);
    end
  end
endmodule : pte_partner
`default_nettype wire

// File: bench/pwm_trip_and_event_trigger_tb_top.sv
// Self-checking testbench of the trip and event trigger block
`timescale 1ns/1ps
`default_nettype none
`include "pte_regs.svh"
module pwm_trip_and_event_trigger_tb_top
  import pte_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [7:0] TSRC = 8'h48, TACT = 8'h50, TIEN = 8'h54, TFLG = 8'h58, TCLR = 8'h5C,
    TFRC = 8'h60, ESEL = 8'h64, EPS = 8'h68, EFLG = 8'h6C, ECLR = 8'h70, EFRC = 8'h74;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pwm_in_a, pwm_in_b;
  logic trip_irq_request, irq_pulse, conv_start_a, conv_start_b, peer_a;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [5:0] fault_input_n;
  logic [1:0] p, ca, cb;
  pte_tb_evt_type tb_evt;
  pte_pin_type pwm_output_a, pwm_output_b;
  int fail_count, total_checks, irq_seen, conv_a_seen, conv_b_seen, n0;
  logic [2:0] srcs [6] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};

  pte_top i_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tb_evt(tb_evt), .fault_input_n(fault_input_n),
    .pwm_in_a(pwm_in_a), .pwm_in_b(pwm_in_b), .pwm_output_a(pwm_output_a),
    .pwm_output_b(pwm_output_b), .trip_irq_request(trip_irq_request),
    .irq_pulse(irq_pulse), .conv_start_a(conv_start_a), .conv_start_b(conv_start_b));
  pte_partner i_partner (.pclk(pclk), .presetn(presetn), .irq_pulse(irq_pulse),
    .conv_start_a(conv_start_a), .conv_start_b(conv_start_b), .peer_start_a(peer_a),
    .peer_start_b(1'b0), .irq_seen(irq_seen), .conv_a_seen(conv_a_seen),
    .conv_b_seen(conv_b_seen));

  // ----------------------------------------
  // Tasks and expectation functions
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask : chk
  // APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // A slave that never answers ends the run
    if (n >= 20) begin
      fail_count++;
      conclude();
    end
    rv = prdata;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic ev(input pte_tb_evt_type e);
    @(posedge pclk) tb_evt <= e;
    @(posedge pclk) tb_evt <= '0;
    repeat ($urandom_range(2)) @(posedge pclk);
  endtask : ev
  task automatic idle(input int c);
    repeat (c) @(posedge pclk);
  endtask : idle
  // Good event of a source, or a near miss that must not count
  function automatic pte_tb_evt_type evt_of(input logic [2:0] s, input bit g);
    pte_tb_evt_type e;
    e = '0;
    e.zero = (s == 3'h1) ? g : (s == 3'h2 && !g);
    e.period = (s == 3'h2) ? g : (s == 3'h1 && !g);
    e.compare_a_value = s[2] && !s[1];
    e.compare_b_value = s[2] && s[1];
    e.count_up = s[2] ? !(s[0] ^ !g) : 1'($urandom);
    return e;
  endfunction : evt_of
  // Hi-Z leaves the level undefined, so only the enable is compared
  function automatic logic [31:0] pin_s(input pte_pin_type q, input logic [1:0] c);
    return (c == 2'h0) ? {31'h0, q.oe} : {30'h0, q};
  endfunction : pin_s
  function automatic logic [31:0] pin_e(input logic [1:0] c, input logic w);
    return (c == 2'h3) ? {30'h0, w, 1'b1} : {30'h0, c == 2'h1, c != 2'h0};
  endfunction : pin_e

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, peer_a} = '0;
    {tb_evt, pwm_in_a, pwm_in_b} = '0;
    fault_input_n = 6'h3F;
    void'($urandom(32'h2717C012));
    idle(6);
    presetn <= 1'b1;
    apb(0, TACT, 0);
    chk(rv, 32'hF);
    apb(0, 8'h4C, 0);
    chk({rv[30:0], pslverr}, 32'h1);
    for (int k = 0; k < 4; k++) begin
      {pwm_in_a, pwm_in_b} <= 2'($urandom);
      {ca, cb} = {2'(k), 2'(3 - k)};
      apb(1, TIEN, (k != 0) ? 32'h4 : 32'h0);
      apb(1, TACT, {28'h0, cb, ca});
      apb(1, TFRC, 32'h4);
      idle(8);
      chk(pin_s(pwm_output_a, ca), pin_e(ca, pwm_in_a));
      chk(pin_s(pwm_output_b, cb), pin_e(cb, pwm_in_b));
      chk(32'(trip_irq_request), 32'(k != 0));
      apb(0, TFLG, 0);
      chk(rv, (k != 0) ? 32'h5 : 32'h4);
      apb(1, TCLR, 32'h5);
      apb(0, TFLG, 0);
      chk(rv, 32'h0);
    end
    apb(1, TSRC, 32'h100);
    @(posedge pclk) fault_input_n <= 6'h3E;
    @(posedge pclk) fault_input_n <= 6'h3F;
    idle(5);
    apb(0, TFLG, 0);
    chk(rv, 32'h5);
    for (int i = 0; i < 6; i++) begin
      p = 2'(1 + i % 3);
      apb(1, ESEL, {28'h0, 1'b1, srcs[i]});
      apb(1, EPS, {30'h0, p});
      n0 = irq_seen;
      // Second batch meets a pending flag and must halt
      repeat (2) begin
        for (int j = 0; j < p; j++) begin
          ev(evt_of(srcs[i], 1'b0));
          ev(evt_of(srcs[i], 1'b1));
        end
        idle(4);
      end
      chk(irq_seen - n0, 1);
      apb(0, EPS, 0);
      chk(rv, {28'h0, p, p});
      apb(1, ECLR, 32'h1);
      idle(4);
      chk(irq_seen - n0, 2);
      apb(0, EPS, 0);
      chk(rv, {30'h0, p});
      apb(1, ECLR, 32'h1);
    end
    apb(1, EPS, 32'h1);
    n0 = irq_seen;
    apb(1, EFRC, 32'h1);
    idle(4);
    chk(irq_seen - n0, 1);
    apb(1, ECLR, 32'h1);
    apb(1, EPS, 32'h0);
    apb(1, EFRC, 32'h1);
    idle(4);
    chk(irq_seen - n0, 1);
    apb(1, ESEL, 32'hFC00);
    apb(1, EPS, 32'h1200);
    n0 = conv_a_seen;
    for (int j = 0; j < 6; j++) begin
      ev(evt_of(3'h4, 1'b1));
      ev(evt_of(3'h7, 1'b1));
    end
    idle(4);
    chk(conv_a_seen - n0, 3);
    chk(conv_b_seen, 6);
    apb(0, EFLG, 0);
    chk(rv, 32'hC);
    apb(1, ESEL, 32'h7400);
    for (int j = 0; j < 3; j++) begin
      ev(evt_of(3'h4, 1'b1));
      ev(evt_of(3'h7, 1'b1));
    end
    @(posedge pclk) peer_a <= 1'b1;
    @(posedge pclk) peer_a <= 1'b0;
    idle(4);
    chk(conv_a_seen - n0, 4);
    apb(0, EPS, 0);
    chk(rv, 32'h5A00);
    apb(1, ECLR, 32'hC);
    apb(0, EFLG, 0);
    chk(rv, 32'h0);
    apb(0, ECLR, 0);
    chk(rv, 32'h0);
    conclude();
  end
endmodule : pwm_trip_and_event_trigger_tb_top
`default_nettype wire
